// ### hw/abth_master.sv
// Processor end: bus master, DMA arbiter and interrupt acceptor
`default_nettype none
`include "abth_defines.svh"

module abth_master (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   abth_bus_if.master       bus,
   input  wire logic        req_valid,
   input  wire logic        req_write,
   input  wire logic        req_byte,
   input  wire logic [15:0] req_addr,
   input  wire logic [15:0] req_wdata,
   output var  logic        req_ready,
   output var  logic        rsp_valid,
   output var  logic [15:0] rsp_rdata,
   output var  logic [2:0]  irq_level,
   input  wire logic        irq_take,
   output var  logic        irq_vector_valid,
   output var  logic        dma_granted
);
   localparam abth_pkg::abth_cnt_t SETUP_CNT  = abth_pkg::abth_cnt_t'(`ABTH_ADDR_SETUP_CYC - 1);
   localparam abth_pkg::abth_cnt_t DESKEW_CNT = abth_pkg::abth_cnt_t'(`ABTH_DESKEW_CYC - 1);

   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   logic [15:0] dal_s;
   logic [4:0]  ctl_s;
   logic        reply_s;
   logic        dreq_s;
   logic        ack_s;
   logic        irq7_s;
   logic        evnt_s;

   abth_sync #(.W(16)) u_sync_dal (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       (bus.muxed_data_address_lines),
      .q       (dal_s)
   );

   abth_sync #(.W(5)) u_sync_ctl (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       ({bus.slave_reply, bus.dma_request, bus.dma_mastership_ack,
                 bus.irq_level_seven, bus.external_event_irq}),
      .q       (ctl_s)
   );

   assign {reply_s, dreq_s, ack_s, irq7_s, evnt_s} = ctl_s;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic in_io_bank(input logic [15:0] a);
      in_io_bank = (a[`ABTH_BANK_MSB:`ABTH_BANK_LSB] == `ABTH_IO_BANK_TOP);
   endfunction

   function automatic logic [2:0] irq_prio(input logic l7, input logic ev);
      if (l7) begin
         irq_prio = `ABTH_LVL_SEVEN;
      end else if (ev) begin
         irq_prio = `ABTH_LVL_EVENT;
      end else begin
         irq_prio = `ABTH_LVL_NONE;
      end
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   abth_pkg::abth_mst_s q;
   abth_pkg::abth_mst_s nxt_q;

   always_comb begin
      nxt_q           = q;
      nxt_q.rsp_valid = 1'b0;
      nxt_q.vec_valid = 1'b0;
      nxt_q.irq_lvl   = irq_prio(irq7_s, evnt_s);
      unique case (q.st)
         abth_pkg::m_idle: begin
            // Bus is free here, so this is the only place the grant may start
            if (dreq_s) begin
               nxt_q.grant = 1'b1;
               nxt_q.ready = 1'b0;
               nxt_q.st    = abth_pkg::m_grant;
            end else if (irq_take && q.irq_lvl != `ABTH_LVL_NONE) begin
               nxt_q.iako  = 1'b1;
               nxt_q.din   = 1'b1;
               nxt_q.interrupt_ack_transaction   = 1'b1;
               nxt_q.ready = 1'b0;
               nxt_q.st    = abth_pkg::m_iak;
            end else if (req_valid) begin
               nxt_q.wr      = req_write;
               nxt_q.byt     = req_write & req_byte;
               nxt_q.wdata   = req_wdata;
               nxt_q.interrupt_ack_transaction     = 1'b0;
               nxt_q.dal_out = req_addr;
               nxt_q.dal_oe  = 1'b1;
               nxt_q.bs7     = in_io_bank(req_addr);
               nxt_q.wtbt    = req_write;
               nxt_q.cnt     = SETUP_CNT;
               nxt_q.ready   = 1'b0;
               nxt_q.st      = abth_pkg::m_addr;
            end
         end
         abth_pkg::m_addr: begin
            if (q.cnt == '0) begin
               nxt_q.sync = 1'b1;
               nxt_q.st   = abth_pkg::m_sync;
            end else begin
               nxt_q.cnt = q.cnt - 1'b1;
            end
         end
         abth_pkg::m_sync: begin
            // Address has been latched by the frame edge; addressing portion ends
            nxt_q.bs7 = 1'b0;
            if (q.wr) begin
               nxt_q.dal_out = q.wdata;
               nxt_q.wtbt    = q.byt;
               nxt_q.cnt     = DESKEW_CNT;
               nxt_q.st      = abth_pkg::m_wsetup;
            end else begin
               nxt_q.dal_oe = 1'b0;
               nxt_q.wtbt   = 1'b0;
               nxt_q.din    = 1'b1;
               nxt_q.st     = abth_pkg::m_din;
            end
         end
         abth_pkg::m_wsetup: begin
            if (q.cnt == '0) begin
               nxt_q.dout = 1'b1;
               nxt_q.st   = abth_pkg::m_dout;
            end else begin
               nxt_q.cnt = q.cnt - 1'b1;
            end
         end
         abth_pkg::m_dout: begin
            // Output strobe stays up until the slave says it has taken the data
            if (reply_s) begin
               nxt_q.dout = 1'b0;
               nxt_q.wtbt = 1'b0;
               nxt_q.st   = abth_pkg::m_release;
            end
         end
         abth_pkg::m_din, abth_pkg::m_iak: begin
            if (reply_s) begin
               nxt_q.cnt = DESKEW_CNT;
               nxt_q.st  = abth_pkg::m_dskew;
            end
         end
         abth_pkg::m_dskew: begin
            if (q.cnt == '0) begin
               nxt_q.rdata     = dal_s;
               nxt_q.din       = 1'b0;
               nxt_q.iako      = 1'b0;
               nxt_q.rsp_valid = ~q.interrupt_ack_transaction;
               nxt_q.vec_valid = q.interrupt_ack_transaction;
               nxt_q.st        = abth_pkg::m_release;
            end else begin
               nxt_q.cnt = q.cnt - 1'b1;
            end
         end
         abth_pkg::m_release: begin
            // Frame is held until the slave lets go of reply
            if (!reply_s) begin
               nxt_q.sync   = 1'b0;
               nxt_q.dal_oe = 1'b0;
               nxt_q.ready  = 1'b1;
               nxt_q.st     = abth_pkg::m_idle;
            end
         end
         abth_pkg::m_grant: begin
            if (ack_s) begin
               nxt_q.grant     = 1'b0;
               nxt_q.dma_owner = 1'b1;
            end else if (q.dma_owner || !dreq_s) begin
               // Owner released the bus, or the request was withdrawn
               nxt_q.grant     = 1'b0;
               nxt_q.dma_owner = 1'b0;
               nxt_q.ready     = 1'b1;
               nxt_q.st        = abth_pkg::m_idle;
            end
         end
         default: begin
            nxt_q = q;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q       <= '0;
         q.st    <= abth_pkg::m_idle;
         q.ready <= 1'b1;
      end else begin
         q <= nxt_q;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bus.dal_m_out            = q.dal_out;
   assign bus.dal_m_oe             = q.dal_oe;
   assign bus.address_frame        = q.sync;
   assign bus.data_output_strobe   = q.dout;
   assign bus.data_input_strobe    = q.din;
   assign bus.write_byte_qualifier = q.wtbt;
   assign bus.io_bank_select       = q.bs7;
   assign bus.dma_grant_out        = q.grant;
   assign bus.interrupt_ack_out    = q.iako;

   assign req_ready        = q.ready;
   assign rsp_valid        = q.rsp_valid;
   assign rsp_rdata        = q.rdata;
   assign irq_level        = q.irq_lvl;
   assign irq_vector_valid = q.vec_valid;
   assign dma_granted      = q.dma_owner;
endmodule

`default_nettype wire

// ### hw/abth_defines.svh
// Timing counts, field positions and interrupt levels of the bus handshake
`ifndef ABTH_DEFINES_SVH
`define ABTH_DEFINES_SVH

`define ABTH_CLK_NS         20
`define ABTH_ADDR_SETUP_NS  150
`define ABTH_DESKEW_NS      100
`define ABTH_ADDR_SETUP_CYC ((`ABTH_ADDR_SETUP_NS + `ABTH_CLK_NS - 1) / `ABTH_CLK_NS)
`define ABTH_DESKEW_CYC     ((`ABTH_DESKEW_NS + `ABTH_CLK_NS - 1) / `ABTH_CLK_NS)
`define ABTH_CNT_W          4
`define ABTH_DAL_W          16
`define ABTH_BANK_MSB       15
`define ABTH_BANK_LSB       12
`define ABTH_IO_BANK_TOP    4'hF
`define ABTH_LVL_NONE       3'h0
`define ABTH_LVL_EVENT      3'h6
`define ABTH_LVL_SEVEN      3'h7
`define ABTH_MEM_AW         6
`define ABTH_MEM_DEPTH      64

`endif

// ### hw/abth_pkg.sv
// Types shared by both ends of the bus handshake
`default_nettype none
`include "abth_defines.svh"

package abth_pkg;
   typedef logic [`ABTH_DAL_W-1:0] abth_word_t;
   typedef logic [`ABTH_CNT_W-1:0] abth_cnt_t;

   typedef enum logic [3:0] {
      m_idle, m_addr, m_sync, m_wsetup, m_dout, m_din, m_dskew, m_release, m_grant, m_iak
   } abth_mst_e;

   typedef enum logic [2:0] {
      s_idle, s_frame, s_read, s_hold, s_vector
   } abth_slv_e;

   typedef struct packed {
      abth_mst_e  st;
      abth_cnt_t  cnt;
      abth_word_t wdata;
      logic       wr;
      logic       byt;
      logic       interrupt_ack_transaction;
      abth_word_t dal_out;
      logic       dal_oe;
      logic       sync;
      logic       dout;
      logic       din;
      logic       wtbt;
      logic       bs7;
      logic       grant;
      logic       iako;
      logic       ready;
      logic       rsp_valid;
      logic       vec_valid;
      abth_word_t rdata;
      logic [2:0] irq_lvl;
      logic       dma_owner;
   } abth_mst_s;

   typedef struct packed {
      abth_slv_e  st;
      abth_word_t addr;
      abth_word_t dal_out;
      logic       dal_oe;
      logic       reply;
      logic       dreq;
      logic       ack;
      logic       irq7;
      logic       evnt;
   } abth_slv_s;
endpackage

`default_nettype wire

// ### hw/abth_bus_if.sv
// Backplane wires between the processor end and a slave or DMA module
`default_nettype none

interface abth_bus_if;
   logic [15:0] dal_m_out;
   logic        dal_m_oe;
   logic [15:0] dal_s_out;
   logic        dal_s_oe;
   logic [15:0] muxed_data_address_lines;
   logic        address_frame;
   logic        data_output_strobe;
   logic        data_input_strobe;
   logic        write_byte_qualifier;
   logic        io_bank_select;
   logic        dma_grant_out;
   logic        interrupt_ack_out;
   logic        interrupt_ack_in;
   logic        slave_reply;
   logic        dma_request;
   logic        dma_mastership_ack;
   logic        irq_level_seven;
   logic        external_event_irq;

   // Open-collector lines resolve as a wired OR of whoever drives them
   assign muxed_data_address_lines = (dal_m_oe ? dal_m_out : 16'h0000)
                                   | (dal_s_oe ? dal_s_out : 16'h0000);
   // First device in the acknowledge daisy chain
   assign interrupt_ack_in = interrupt_ack_out;

   modport master (
      output dal_m_out, dal_m_oe, address_frame, data_output_strobe, data_input_strobe,
             write_byte_qualifier, io_bank_select, dma_grant_out, interrupt_ack_out,
      input  muxed_data_address_lines, slave_reply, dma_request, dma_mastership_ack,
             irq_level_seven, external_event_irq
   );

   modport slave (
      output dal_s_out, dal_s_oe, slave_reply, dma_request, dma_mastership_ack,
             irq_level_seven, external_event_irq,
      input  muxed_data_address_lines, address_frame, data_output_strobe,
             data_input_strobe, write_byte_qualifier, io_bank_select, dma_grant_out,
             interrupt_ack_in
   );
endinterface

`default_nettype wire

// ### hw/abth_sync.sv
// Two-stage synchroniser for backplane inputs
`default_nettype none

module abth_sync #(
   parameter int W = 1
) (
   input  wire logic         clk_sys,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);
   logic [W-1:0] meta_ff;

   // First stage feeds only the second stage
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_ff <= '0;
         q       <= '0;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule

`default_nettype wire

// ### hw/abth_slave.sv
// Backplane end: memory slave, interrupt source and DMA requester
`default_nettype none
`include "abth_defines.svh"

module abth_slave (
   input  wire logic        clk_sys,
   input  wire logic        rst_n,
   abth_bus_if.slave        bus,
   input  wire logic        irq7_req,
   input  wire logic        event_req,
   input  wire logic [15:0] irq_vector,
   input  wire logic        dma_want,
   output var  logic        dma_owned
);
   // ----------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------
   logic [15:0] dal_s;
   logic [5:0]  ctl_s;
   logic        sync_s;
   logic        dout_s;
   logic        din_s;
   logic        wtbt_s;
   logic        grant_s;
   logic        iaki_s;

   abth_sync #(.W(16)) u_sync_dal (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       (bus.muxed_data_address_lines),
      .q       (dal_s)
   );

   abth_sync #(.W(6)) u_sync_ctl (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .d       ({bus.address_frame, bus.data_output_strobe, bus.data_input_strobe,
                 bus.write_byte_qualifier, bus.dma_grant_out, bus.interrupt_ack_in}),
      .q       (ctl_s)
   );

   assign {sync_s, dout_s, din_s, wtbt_s, grant_s, iaki_s} = ctl_s;

   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   logic [15:0] mem [`ABTH_MEM_DEPTH];
   logic [`ABTH_MEM_AW-1:0] idx;
   logic        wr_en;

   abth_pkg::abth_slv_s q;
   abth_pkg::abth_slv_s nxt_q;

   assign idx   = q.addr[`ABTH_MEM_AW:1];
   assign wr_en = (q.st == abth_pkg::s_frame) && dout_s;

   always_comb begin
      nxt_q      = q;
      nxt_q.irq7 = irq7_req;
      nxt_q.evnt = event_req;
      // DMA request, then acknowledge once the grant arrives
      if (q.ack) begin
         nxt_q.ack = dma_want;
      end else if (q.dreq && grant_s) begin
         nxt_q.dreq = 1'b0;
         nxt_q.ack  = 1'b1;
      end else begin
         nxt_q.dreq = dma_want;
      end
      unique case (q.st)
         abth_pkg::s_idle: begin
            if (sync_s) begin
               nxt_q.addr = dal_s;
               nxt_q.st   = abth_pkg::s_frame;
            end else if (din_s && iaki_s && (irq7_req || event_req)) begin
               nxt_q.dal_out = irq_vector;
               nxt_q.dal_oe  = 1'b1;
               nxt_q.st      = abth_pkg::s_vector;
            end
         end
         abth_pkg::s_frame: begin
            if (!sync_s) begin
               nxt_q.st = abth_pkg::s_idle;
            end else if (dout_s) begin
               nxt_q.reply = 1'b1;
               nxt_q.st    = abth_pkg::s_hold;
            end else if (din_s) begin
               nxt_q.dal_out = mem[idx];
               nxt_q.dal_oe  = 1'b1;
               nxt_q.st      = abth_pkg::s_read;
            end
         end
         abth_pkg::s_read, abth_pkg::s_vector: begin
            // Data went out a cycle earlier, so reply follows it
            nxt_q.reply = 1'b1;
            nxt_q.st    = abth_pkg::s_hold;
         end
         abth_pkg::s_hold: begin
            if (!dout_s && !din_s) begin
               nxt_q.reply  = 1'b0;
               nxt_q.dal_oe = 1'b0;
               nxt_q.st     = sync_s ? abth_pkg::s_frame : abth_pkg::s_idle;
            end
         end
         default: begin
            nxt_q = q;
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         q    <= '0;
         q.st <= abth_pkg::s_idle;
      end else begin
         q <= nxt_q;
      end
   end

   // Byte lane picked by address bit zero when the qualifier is set
   always_ff @(posedge clk_sys) begin
      if (wr_en) begin
         if (!wtbt_s) begin
            mem[idx] <= dal_s;
         end else if (q.addr[0]) begin
            mem[idx][15:8] <= dal_s[15:8];
         end else begin
            mem[idx][7:0] <= dal_s[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign bus.dal_s_out          = q.dal_out;
   assign bus.dal_s_oe           = q.dal_oe;
   assign bus.slave_reply        = q.reply;
   assign bus.dma_request        = q.dreq;
   assign bus.dma_mastership_ack = q.ack;
   assign bus.irq_level_seven    = q.irq7;
   assign bus.external_event_irq = q.evnt;
   assign dma_owned              = q.ack;
endmodule

`default_nettype wire

// ### sim/abth_bus_properties.sv
// Concurrent checks on the wires between the two ends of the bus handshake
`default_nettype none

module abth_bus_properties (
   input wire logic        clk_sys,
   input wire logic        rst_n,
   input wire logic [15:0] dal_m_out,
   input wire logic        dal_m_oe,
   input wire logic        address_frame,
   input wire logic        data_output_strobe,
   input wire logic        data_input_strobe,
   input wire logic        write_byte_qualifier,
   input wire logic        io_bank_select,
   input wire logic        dma_grant_out,
   input wire logic        interrupt_ack_out,
   input wire logic        slave_reply,
   input wire logic        dma_request
);
   // ---------------------------------------------
   // Handshake relations
   // ---------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   dout_valid_data_a: assert property (
      data_output_strobe |-> dal_m_oe && address_frame)
      else $error("output strobe without driven data");
   dout_deskew_a: assert property (
      $rose(data_output_strobe) |-> $past(dal_m_oe, 4) && dal_m_out == $past(dal_m_out, 4))
      else $error("output strobe not delayed behind data");
   dout_reply_a: assert property (
      $fell(data_output_strobe) |-> $past(slave_reply) && $past(slave_reply, 3))
      else $error("output strobe ended without reply");
   din_deskew_a: assert property (
      $fell(data_input_strobe) |-> $past(slave_reply) && $past(slave_reply, 6))
      else $error("input sampled before deskew");
   din_kind_a: assert property (
      data_input_strobe |-> address_frame != interrupt_ack_out)
      else $error("input strobe neither transfer nor acknowledge");
   write_kind_a: assert property (
      $rose(address_frame) && write_byte_qualifier |-> ##[1:12] data_output_strobe)
      else $error("write frame gave no output strobe");
   read_kind_a: assert property (
      $rose(address_frame) && !write_byte_qualifier |-> ##[1:12] data_input_strobe)
      else $error("read frame gave no input strobe");
   frame_setup_a: assert property (
      $rose(address_frame) |-> $past(dal_m_oe, 6) && dal_m_out == $past(dal_m_out, 6))
      else $error("frame raised before address settled");
   frame_hold_a: assert property (
      address_frame && (data_output_strobe || data_input_strobe || slave_reply)
      |=> address_frame)
      else $error("frame dropped during handshake");
   bank_select_a: assert property (
      $rose(address_frame) |-> io_bank_select == (dal_m_out[15:12] == 4'hF))
      else $error("bank select disagrees with address");
   grant_idle_a: assert property (
      dma_grant_out |-> !address_frame && !dal_m_oe)
      else $error("grant while processor is master");
   grant_request_a: assert property (
      $rose(dma_grant_out) |-> $past(dma_request) && $past(dma_request, 2))
      else $error("grant without request");
endmodule

`default_nettype wire

// ### sim/async_bus_transfer_handshake_tb_top.sv
// Bench joining the processor end and the backplane end of the handshake
`default_nettype none

module async_bus_transfer_handshake_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        req_valid = 1'b0;
   logic        req_write = 1'b0;
   logic        req_byte = 1'b0;
   logic [15:0] req_addr = 16'h0000;
   logic [15:0] req_wdata = 16'h0000;
   logic        irq_take = 1'b0;
   logic        irq7_req = 1'b0;
   logic        event_req = 1'b0;
   logic [15:0] irq_vector = 16'h0000;
   logic        dma_want = 1'b0;
   logic        req_ready, rsp_valid, irq_vector_valid, dma_granted, dma_owned;
   logic [15:0] rsp_rdata;
   logic [2:0]  irq_level;
   logic        wtbt_dout = 1'b0;
   int          bank_cycles = 0;
   int          bad_count = 0;
   int          total_checks = 0;

   always #10 clk_sys = ~clk_sys;

   abth_bus_if bus ();
   abth_master u_abth_master (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus.master),
      .req_valid(req_valid), .req_write(req_write), .req_byte(req_byte),
      .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
      .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .irq_level(irq_level),
      .irq_take(irq_take), .irq_vector_valid(irq_vector_valid), .dma_granted(dma_granted));
   abth_slave u_abth_slave (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus.slave),
      .irq7_req(irq7_req), .event_req(event_req), .irq_vector(irq_vector),
      .dma_want(dma_want), .dma_owned(dma_owned));
   abth_bus_properties u_abth_bus_properties (.clk_sys(clk_sys), .rst_n(rst_n),
      .dal_m_out(bus.dal_m_out), .dal_m_oe(bus.dal_m_oe), .address_frame(bus.address_frame),
      .data_output_strobe(bus.data_output_strobe), .data_input_strobe(bus.data_input_strobe),
      .write_byte_qualifier(bus.write_byte_qualifier), .io_bank_select(bus.io_bank_select),
      .dma_grant_out(bus.dma_grant_out), .interrupt_ack_out(bus.interrupt_ack_out),
      .slave_reply(bus.slave_reply), .dma_request(bus.dma_request));

   // Qualifier seen under the output strobe, and a running count of bank select cycles;
   // only this block writes them, so scenarios compare against a snapshot
   always @(posedge clk_sys) begin
      if (bus.data_output_strobe === 1'b1) wtbt_dout <= bus.write_byte_qualifier;
      if (bus.io_bank_select === 1'b1) bank_cycles <= bank_cycles + 1;
   end

   // ---------------------------------------------
   // Shared tasks
   // ---------------------------------------------
   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   function automatic logic [15:0] probe(input int sel);
      case (sel)
         0: return 16'(req_ready);
         1: return 16'(rsp_valid);
         2: return 16'(irq_level);
         3: return 16'(irq_vector_valid);
         default: return 16'(dma_granted);
      endcase
   endfunction

   // Slave replies are unbounded by design, so every wait carries its own limit
   task automatic wait_for(input int sel, input logic [15:0] v, input string what);
      int n = 0;
      while (probe(sel) !== v) begin
         @(posedge clk_sys);
         #2;
         n++;
         if (n > 400) begin
            bad_count++;
            $display("BAD %s expected %h seen timeout", what, v);
            complete_run();
         end
      end
   endtask

   task automatic bus_op(input logic wr, input logic bt, input logic [15:0] a,
                         input logic [15:0] d, output logic [15:0] q);
      wait_for(0, 16'h0001, "ready");
      req_valid = 1'b1;
      req_write = wr;
      req_byte = bt;
      req_addr = a;
      req_wdata = d;
      @(posedge clk_sys);
      #2;
      req_valid = 1'b0;
      if (!wr) wait_for(1, 16'h0001, "read answer");
      q = rsp_rdata;
      wait_for(0, 16'h0001, "ready");
   endtask

   // ---------------------------------------------
   // Scenarios
   // ---------------------------------------------
   task automatic t_word();
      logic [15:0] q;
      int          b0;
      b0 = bank_cycles;
      bus_op(1'b1, 1'b0, 16'h0010, 16'h1234, q);
      chk("word qualifier", 16'h0000, 16'(wtbt_dout));
      chk("low bank select", 16'h0000, 16'(bank_cycles != b0));
      bus_op(1'b0, 1'b0, 16'h0010, 16'h0000, q);
      chk("word readback", 16'h1234, q);
   endtask

   task automatic t_byte();
      logic [15:0] q;
      bus_op(1'b1, 1'b1, 16'h0011, 16'hAB00, q);
      chk("byte qualifier", 16'h0001, 16'(wtbt_dout));
      bus_op(1'b1, 1'b1, 16'h0010, 16'h00CD, q);
      bus_op(1'b0, 1'b0, 16'h0010, 16'h0000, q);
      chk("byte merge", 16'hABCD, q);
   endtask

   task automatic t_bank();
      logic [15:0] q;
      int          b0;
      b0 = bank_cycles;
      bus_op(1'b1, 1'b0, 16'hF004, 16'h5A5A, q);
      chk("io bank select", 16'h0001, 16'(bank_cycles != b0));
      bus_op(1'b0, 1'b0, 16'hF004, 16'h0000, q);
      chk("io readback", 16'h5A5A, q);
   endtask

   task automatic t_irq();
      irq_vector = 16'h00B8;
      event_req = 1'b1;
      wait_for(2, 16'h0006, "event level");
      irq7_req = 1'b1;
      wait_for(2, 16'h0007, "level seven");
      irq7_req = 1'b0;
      wait_for(2, 16'h0006, "event level");
      irq_take = 1'b1;
      @(posedge clk_sys);
      #2;
      irq_take = 1'b0;
      wait_for(3, 16'h0001, "vector");
      chk("vector", 16'h00B8, rsp_rdata);
      event_req = 1'b0;
      wait_for(2, 16'h0000, "no level");
      wait_for(0, 16'h0001, "ready");
   endtask

   task automatic t_dma();
      dma_want = 1'b1;
      wait_for(4, 16'h0001, "dma granted");
      chk("dma owned", 16'h0001, 16'(dma_owned));
      dma_want = 1'b0;
      wait_for(4, 16'h0000, "dma released");
      wait_for(0, 16'h0001, "ready");
   endtask

   task automatic t_reset();
      logic [15:0] q;
      req_valid = 1'b1;
      req_write = 1'b1;
      req_addr = 16'h0020;
      @(posedge clk_sys);
      #2;
      req_valid = 1'b0;
      repeat (10) @(posedge clk_sys);
      #2;
      rst_n = 1'b0;
      #1;
      chk("frame in reset", 16'h0000, 16'(bus.address_frame));
      chk("ready in reset", 16'h0001, 16'(req_ready));
      repeat (3) @(posedge clk_sys);
      #2;
      rst_n = 1'b1;
      bus_op(1'b1, 1'b0, 16'h0030, 16'h0F0F, q);
      bus_op(1'b0, 1'b0, 16'h0030, 16'h0000, q);
      chk("readback after reset", 16'h0F0F, q);
   endtask

   initial begin
      repeat (3) @(posedge clk_sys);
      #2;
      rst_n = 1'b1;
      chk("ready after reset", 16'h0001, 16'(req_ready));
      t_word();
      t_byte();
      t_bank();
      t_irq();
      t_dma();
      t_reset();
      complete_run();
   end
endmodule

`default_nettype wire
